//--- verilog/eeprom_access_controller.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
// Function
// - 9-bit address from high bit0 and low
// - software loads address before any access
// - data byte feeds writes, receives reads
// - mode bits select atomic, erase, write
// - atomic 3.4 ms, split 1.8 ms
// - mode writes ignored while busy
// - reset clears mode unless busy
// - ready interrupt level when enabled, idle
// - master enable self-clears after four cycles
// - program only within master enable window
// - program enable busy until time elapses
// - program start stalls core two cycles
// - read loads data, stalls four cycles
// - busy blocks reads and address changes
// - software polls busy before reading
// - control bits 7,6 read zero
// - high address bits 7:1 read zero
// - write-only on unerased byte corrupts
// - reset lets running program finish
module eeprom_access_controller #(
	parameter int ATOMIC_CYC = nvm_access_pkg::ATOMIC_CYCLES,
	parameter int SPLIT_CYC = nvm_access_pkg::SPLIT_CYCLES
)(
	input wire logic core_clk,
	input wire logic reset,
	nvm_io_if.device io,
	input wire logic globalIrqEnable
);
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] data;
		logic [1:0] mode;
		logic readyIe;
		logic [2:0] masterCnt;
		logic busy;
		logic [1:0] busyMode;
		logic [31:0] progCnt;
		logic [2:0] stallCnt;
		logic [7:0] rdata;
	} state_t;
	state_t cur_ff;
	state_t nxt_cur;
	logic [7:0] mem [0:nvm_access_pkg::MEM_BYTES-1];
	logic [7:0] memRead;
	logic [7:0] ctrlView;
	logic wrCtl;
	logic startProg;
	logic doRead;
	logic progDone;
	logic [31:0] progLimit;

	// ------------------------------------------------------------
	// decode and control view
	// ------------------------------------------------------------
	assign wrCtl = io.ioWrite && io.ioAddr == nvm_access_pkg::REG_CONTROL;
	assign memRead = mem[cur_ff.addr];
	always_comb
	begin
		ctrlView = 8'h00;
		ctrlView[nvm_access_pkg::BIT_MODE_HI:nvm_access_pkg::BIT_MODE_LO]
			= cur_ff.mode;
		ctrlView[nvm_access_pkg::BIT_RDY_IE] = cur_ff.readyIe;
		ctrlView[nvm_access_pkg::BIT_MASTER] = cur_ff.masterCnt != 3'h0;
		ctrlView[nvm_access_pkg::BIT_PROG] = cur_ff.busy;
	end
	assign startProg = wrCtl && !cur_ff.busy
		&& io.ioWdata[nvm_access_pkg::BIT_PROG]
		&& cur_ff.masterCnt != 3'h0
		&& cur_ff.mode != nvm_access_pkg::MODE_RSVD;
	assign doRead = wrCtl && !cur_ff.busy
		&& io.ioWdata[nvm_access_pkg::BIT_READ];
	assign progLimit = (cur_ff.busyMode == nvm_access_pkg::MODE_ATOMIC)
		? 32'(ATOMIC_CYC) : 32'(SPLIT_CYC);
	assign progDone = cur_ff.busy && cur_ff.progCnt >= progLimit - 32'h1;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_cur = cur_ff;
		if (cur_ff.masterCnt != 3'h0)
		begin
			nxt_cur.masterCnt = cur_ff.masterCnt - 3'h1;
		end
		if (cur_ff.stallCnt != 3'h0)
		begin
			nxt_cur.stallCnt = cur_ff.stallCnt - 3'h1;
		end
		if (cur_ff.busy)
		begin
			nxt_cur.progCnt = cur_ff.progCnt + 32'h1;
			if (progDone)
			begin
				nxt_cur.busy = 1'b0;
				nxt_cur.progCnt = 32'h0;
			end
		end
		if (io.ioWrite)
		begin
			if (io.ioAddr == nvm_access_pkg::REG_ADDR_LOW && !cur_ff.busy)
			begin
				nxt_cur.addr[7:0] = io.ioWdata;
			end
			else if (io.ioAddr == nvm_access_pkg::REG_ADDR_HIGH
				&& !cur_ff.busy)
			begin
				nxt_cur.addr[8] = io.ioWdata[0];
			end
			else if (io.ioAddr == nvm_access_pkg::REG_DATA)
			begin
				nxt_cur.data = io.ioWdata;
			end
			else if (io.ioAddr == nvm_access_pkg::REG_CONTROL)
			begin
				nxt_cur.readyIe = io.ioWdata[nvm_access_pkg::BIT_RDY_IE];
				if (!cur_ff.busy)
				begin
					nxt_cur.mode = io.ioWdata[5:4];
				end
				if (io.ioWdata[nvm_access_pkg::BIT_MASTER])
				begin
					nxt_cur.masterCnt = 3'(nvm_access_pkg::MASTER_WINDOW);
				end
			end
		end
		if (startProg)
		begin
			nxt_cur.busy = 1'b1;
			nxt_cur.busyMode = cur_ff.mode;
			nxt_cur.progCnt = 32'h0;
			nxt_cur.masterCnt = 3'h0;
			nxt_cur.stallCnt = 3'(nvm_access_pkg::PROG_STALL);
		end
		else if (doRead)
		begin
			nxt_cur.data = memRead;
			nxt_cur.stallCnt = 3'(nvm_access_pkg::READ_STALL);
		end
		nxt_cur.rdata = 8'h00;
		if (io.ioRead)
		begin
			if (io.ioAddr == nvm_access_pkg::REG_CONTROL)
			begin
				nxt_cur.rdata = ctrlView;
			end
			else if (io.ioAddr == nvm_access_pkg::REG_DATA)
			begin
				nxt_cur.rdata = cur_ff.data;
			end
			else if (io.ioAddr == nvm_access_pkg::REG_ADDR_LOW)
			begin
				nxt_cur.rdata = cur_ff.addr[7:0];
			end
			else
			begin
				nxt_cur.rdata = {7'h00, cur_ff.addr[8]};
			end
		end
	end

	// ------------------------------------------------------------
	// registers; programming survives reset
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cur_ff.readyIe <= 1'b0;
			cur_ff.masterCnt <= 3'h0;
			cur_ff.stallCnt <= 3'h0;
			cur_ff.rdata <= 8'h00;
			cur_ff.busyMode <= cur_ff.busyMode;
			// unknown busy at power-up falls to idle
			if (cur_ff.busy)
			begin
				cur_ff.addr <= cur_ff.addr;
				cur_ff.data <= cur_ff.data;
				cur_ff.mode <= cur_ff.mode;
			end
			else
			begin
				cur_ff.addr <= 9'h000;
				cur_ff.data <= nvm_access_pkg::DATA_RESET;
				cur_ff.mode <= nvm_access_pkg::MODE_RESET;
			end
			if (cur_ff.busy && !progDone)
			begin
				cur_ff.busy <= 1'b1;
				cur_ff.progCnt <= cur_ff.progCnt + 32'h1;
			end
			else
			begin
				cur_ff.busy <= 1'b0;
				cur_ff.progCnt <= 32'h0;
			end
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end

	// ------------------------------------------------------------
	// byte array; write-only ANDs, so unerased bytes corrupt
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (progDone)
		begin
			if (cur_ff.busyMode == nvm_access_pkg::MODE_ATOMIC)
			begin
				mem[cur_ff.addr] <= cur_ff.data;
			end
			else if (cur_ff.busyMode == nvm_access_pkg::MODE_ERASE)
			begin
				mem[cur_ff.addr] <= nvm_access_pkg::ERASED_BYTE;
			end
			else
			begin
				mem[cur_ff.addr] <= memRead & cur_ff.data;
			end
		end
	end

	assign io.ioRdata = cur_ff.rdata;
	assign io.cpuStall = cur_ff.stallCnt != 3'h0;
	assign io.readyIrq = cur_ff.readyIe && globalIrqEnable
		&& !cur_ff.busy;
endmodule

//--- verilog/nvm_access_pkg.sv
package nvm_access_pkg;
	// ------------------------------------------------------------
	// register indices on the I/O register port
	// ------------------------------------------------------------
	localparam logic [1:0] REG_CONTROL = 2'h0;
	localparam logic [1:0] REG_DATA = 2'h1;
	localparam logic [1:0] REG_ADDR_LOW = 2'h2;
	localparam logic [1:0] REG_ADDR_HIGH = 2'h3;
	// ------------------------------------------------------------
	// control field positions
	// ------------------------------------------------------------
	localparam int BIT_READ = 0;
	localparam int BIT_PROG = 1;
	localparam int BIT_MASTER = 2;
	localparam int BIT_RDY_IE = 3;
	localparam int BIT_MODE_LO = 4;
	localparam int BIT_MODE_HI = 5;
	// ------------------------------------------------------------
	// reset values and modes
	// ------------------------------------------------------------
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] MODE_ATOMIC = 2'h0;
	localparam logic [1:0] MODE_ERASE = 2'h1;
	localparam logic [1:0] MODE_WRITE = 2'h2;
	localparam logic [1:0] MODE_RSVD = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int ATOMIC_US = 3400;
	localparam int SPLIT_US = 1800;
	localparam int ATOMIC_CYCLES = ATOMIC_US * CLK_MHZ;
	localparam int SPLIT_CYCLES = SPLIT_US * CLK_MHZ;
	localparam int MASTER_WINDOW = 4;
	localparam int PROG_STALL = 2;
	localparam int READ_STALL = 4;
	localparam int MEM_BYTES = 512;
	localparam int ADDR_BITS = 9;
endpackage

//--- verilog/nvm_io_if.sv
`timescale 1ns/1ps
interface nvm_io_if;
	logic [1:0] ioAddr;
	logic [7:0] ioWdata;
	logic ioWrite;
	logic ioRead;
	logic [7:0] ioRdata;
	logic cpuStall;
	logic readyIrq;
	modport device (input ioAddr, ioWdata, ioWrite, ioRead,
		output ioRdata, cpuStall, readyIrq);
	modport core (output ioAddr, ioWdata, ioWrite, ioRead,
		input ioRdata, cpuStall, readyIrq);
endinterface

//--- verilog/nvm_core_port.sv
`timescale 1ns/1ps
// core-side end: turns user requests into I/O register cycles
module nvm_core_port (
	input wire logic core_clk,
	input wire logic reset,
	nvm_io_if.core io,
	input wire logic reqWrite,
	input wire logic reqRead,
	input wire logic [1:0] reqAddr,
	input wire logic [7:0] reqData,
	output logic reqReady,
	output logic [7:0] rspData,
	output logic rspValid,
	output logic stalled,
	output logic irqPending
);
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic rdPend;
		logic [7:0] rsp;
		logic rspV;
	} state_t;
	state_t cur_ff;
	state_t nxt_cur;

	// ------------------------------------------------------------
	// request issue; held off while the device stalls the core
	// ------------------------------------------------------------
	assign reqReady = !io.cpuStall;
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.wr = reqWrite && reqReady;
		nxt_cur.rd = reqRead && !reqWrite && reqReady;
		nxt_cur.rdPend = cur_ff.rd;
		nxt_cur.rspV = cur_ff.rdPend;
		if (reqReady && (reqWrite || reqRead))
		begin
			nxt_cur.addr = reqAddr;
			nxt_cur.wdata = reqWrite ? reqData : 8'h00;
		end
		if (cur_ff.rdPend)
		begin
			nxt_cur.rsp = io.ioRdata;
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cur_ff <= '0;
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end
	assign io.ioAddr = cur_ff.addr;
	assign io.ioWdata = cur_ff.wdata;
	assign io.ioWrite = cur_ff.wr;
	assign io.ioRead = cur_ff.rd;
	assign rspData = cur_ff.rsp;
	assign rspValid = cur_ff.rspV;
	assign stalled = io.cpuStall;
	assign irqPending = io.readyIrq;
endmodule

//--- verification/nvm_io_sva.sv
`timescale 1ns/1ps
module nvm_io_sva #(
	parameter int ATOMIC_CYC = 20
)(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [1:0] ioAddr,
	input wire logic [7:0] ioWdata,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioRdata,
	input wire logic cpuStall,
	input wire logic readyIrq,
	input wire logic globalIrqEnable
);
	// ----
	// enable and window tracking
	// ----
	localparam int BMAX = ATOMIC_CYC + 4;
	logic irqEn_ff, ctl, busy, go, rdCtl, rdHigh;
	logic [2:0] win_ff;
	assign ctl = ioWrite && ioAddr == 2'h0;
	assign rdCtl = ioRead && ioAddr == 2'h0;
	assign rdHigh = ioRead && ioAddr == 2'h3;
	assign busy = irqEn_ff && globalIrqEnable && !readyIrq;
	assign go = ctl && ioWdata[1] && win_ff != 3'h0 && !busy
		&& ioWdata[5:4] != 2'h3;
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			irqEn_ff <= 1'b0;
			win_ff <= 3'h0;
		end
		else
		begin
			if (ctl)
				irqEn_ff <= ioWdata[3];
			if (ctl && ioWdata[2])
				win_ff <= 3'h4;
			else if (win_ff != 3'h0)
				win_ff <= win_ff - 3'h1;
		end
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);
	a_rdata_slot: assert property (ioRdata != 8'h00 |-> $past(ioRead))
		else $error("read data outside its slot");
	a_ctrl_rsvd: assert property ($past(rdCtl) |-> ioRdata[7:6] == 2'h0)
		else $error("control top bits not zero");
	a_high_rsvd: assert property ($past(rdHigh) |-> ioRdata[7:1] == 7'h00)
		else $error("high address top bits not zero");
	a_read_stall: assert property (
		ctl && ioWdata[0] && !ioWdata[1] && !busy
		|=> cpuStall [*4] ##1 !cpuStall)
		else $error("read stall not four cycles");
	a_prog_stall: assert property (go |=> cpuStall [*2] ##1 !cpuStall)
		else $error("program stall not two cycles");
	a_busy_hold: assert property (go && ioWdata[3] |=> !readyIrq [*8])
		else $error("ready during programming");
	a_busy_end: assert property (
		go && ioWdata[3] && globalIrqEnable |-> ##[9:BMAX] readyIrq)
		else $error("programming did not end in time");
	a_irq_gate: assert property (readyIrq |-> globalIrqEnable && irqEn_ff)
		else $error("interrupt without enables");
	a_no_master: assert property (
		ctl && ioWdata[1] && win_ff == 3'h0 && !busy |=> !cpuStall)
		else $error("program started without master");
	a_busy_noread: assert property (ctl && ioWdata[0] && busy |=> !cpuStall)
		else $error("read performed while busy");
endmodule

//--- verification/eeprom_access_controller_tb.sv
`timescale 1ns/1ps
module eeprom_access_controller_tb;
	typedef struct packed {logic [1:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	row_t rows [5] = '{'{2'h1, 8'hA5, 8'hA5}, '{2'h2, 8'h3C, 8'h3C},
		'{2'h3, 8'hFF, 8'h01}, '{2'h0, 8'hF8, 8'h38}, '{2'h0, 8'h18, 8'h18}};
	logic core_clk, reset, globalIrqEnable, reqWrite, reqRead;
	logic reqReady, rspValid, irqPending, stalled;
	logic [1:0] reqAddr;
	logic [7:0] reqData, rspData, v;
	int bad_count, n_checks, n;
	nvm_io_if io();
	eeprom_access_controller #(.ATOMIC_CYC(20), .SPLIT_CYC(10))
		eeprom_access_controller_inst (.core_clk, .reset, .io,
		.globalIrqEnable);
	nvm_core_port nvm_core_port_inst (.core_clk, .reset, .io, .reqWrite,
		.reqRead, .reqAddr, .reqData, .reqReady, .rspData, .rspValid,
		.stalled, .irqPending);
	nvm_io_sva #(.ATOMIC_CYC(20)) nvm_io_sva_inst (.core_clk, .reset,
		.ioAddr(io.ioAddr), .ioWdata(io.ioWdata), .ioWrite(io.ioWrite),
		.ioRead(io.ioRead), .ioRdata(io.ioRdata), .cpuStall(io.cpuStall),
		.readyIrq(io.readyIrq), .globalIrqEnable);
	// ----
	// bus and check tasks
	// ----
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(logic [1:0] a, logic [7:0] d);
		@(posedge core_clk);
		reqWrite <= 1'b1;
		reqAddr <= a;
		reqData <= d;
		@(posedge core_clk);
		while (reqReady !== 1'b1)
			@(posedge core_clk);
		reqWrite <= 1'b0;
	endtask
	task automatic rd(logic [1:0] a);
		@(posedge core_clk);
		reqRead <= 1'b1;
		reqAddr <= a;
		@(posedge core_clk);
		while (reqReady !== 1'b1)
			@(posedge core_clk);
		reqRead <= 1'b0;
		n = 0;
		while (rspValid !== 1'b1 && n < 9)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("response", 8'h01, {7'h00, rspValid});
		v = rspData;
	endtask
	task automatic hold(logic l, int lim);
		n = 0;
		while (irqPending !== l && n < lim)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("irq level", {7'h00, l}, {7'h00, irqPending});
	endtask
	task automatic idle(int lo, int hi);
		hold(1'b0, 6);
		hold(1'b1, 99);
		chk("busy time", 8'h01, 8'(n >= lo && n <= hi));
	endtask
	task automatic prog(logic [8:0] ad, logic [7:0] d, logic [1:0] m);
		wr(2'h3, {7'h00, ad[8]});
		wr(2'h2, ad[7:0]);
		wr(2'h1, d);
		wr(2'h0, {2'h0, m, 4'hC});
		wr(2'h0, {2'h0, m, 4'hE});
	endtask
	task automatic rmem(logic [8:0] ad, logic [7:0] e);
		wr(2'h3, {7'h00, ad[8]});
		wr(2'h2, ad[7:0]);
		wr(2'h0, 8'h09);
		n = 0;
		repeat (6)
		begin
			@(posedge core_clk);
			if (stalled === 1'b1)
				n++;
		end
		chk("read stall", 8'(nvm_access_pkg::READ_STALL), 8'(n));
		rd(2'h1);
		chk("memory", e, v);
	endtask
	task automatic final_report();
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----
	// clock, watchdog, tests
	// ----
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		#80000;
		bad_count++;
		final_report();
	end
	initial
	begin
		{reset, globalIrqEnable} = 2'h3;
		{reqWrite, reqRead, reqAddr, reqData} = 12'h000;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rd(2'h0);
		chk("ctrl", 8'h00, v);
		rd(2'h1);
		chk("data", 8'h00, v);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk("reg", rows[i].e, v);
		end
		prog(9'h1A5, 8'h5A, 2'h0);
		idle(18, 24);
		rmem(9'h1A5, 8'h5A);
		prog(9'h1A5, 8'h00, 2'h1);
		idle(8, 14);
		rmem(9'h1A5, 8'hFF);
		prog(9'h0A5, 8'h33, 2'h0);
		hold(1'b0, 6);
		hold(1'b1, 99);
		prog(9'h1A5, 8'h0F, 2'h2);
		wr(2'h2, 8'h00);
		wr(2'h0, 8'h09);
		hold(1'b1, 99);
		rd(2'h0);
		chk("mode", 8'h28, v);
		wr(2'h0, 8'h09);
		rd(2'h1);
		chk("addr", 8'h0F, v);
		rmem(9'h0A5, 8'h33);
		wr(2'h0, 8'h0A);
		rd(2'h0);
		chk("ctrl", 8'h08, v);
		wr(2'h0, 8'h0C);
		rd(2'h0);
		chk("master", 8'h0C, v);
		wr(2'h0, 8'h0A);
		wr(2'h0, 8'h3C);
		wr(2'h0, 8'h3E);
		rd(2'h0);
		chk("ctrl", 8'h38, v & 8'hFB);
		prog(9'h010, 8'h77, 2'h1);
		hold(1'b0, 6);
		reset <= 1'b1;
		@(posedge core_clk);
		reset <= 1'b0;
		rd(2'h0);
		chk("ctrl", 8'h12, v);
		wr(2'h0, 8'h08);
		hold(1'b1, 30);
		rd(2'h0);
		chk("ctrl", 8'h18, v);
		chk("irq", 8'h01, {7'h00, irqPending});
		globalIrqEnable <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("irq", 8'h00, {7'h00, irqPending});
		rmem(9'h010, 8'hFF);
		final_report();
	end
endmodule
